// file: watchdog_ctrl.sv
// watchdog control, interrupt enables and counter behind wishbone
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
module watchdog_ctrl
   import watchdog_pkg::*;
#(
   parameter int CNT_W      = 20,           // counter width
   parameter int TICK_DIV   = TICK_CYCLES   // cycles per count tick
) (
   input  wire logic        clk_i,          // 250 MHz clock
   input  wire logic        rst_i,          // power-on reset, sync
   // user row values, sampled in reset
   input  wire logic        nvm_lock_i,     // lock start value
   input  wire logic        nvm_window_i,   // window start value
   input  wire logic        nvm_enable_i,   // enable start value
   // wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // outputs
   output logic             irq_o,          // level interrupt
   output logic             sys_reset_o,    // one-cycle reset pulse
   output logic             running_o       // counter is active
);
   import watchdog_pkg::*;

   // software-visible state; the three control bits take the user
   // row values in reset, so none of them has a fixed reset value,
   // while the setup registers start from package constants
   logic               permanent_run_lock;  // lock bit
   logic               window_mode;         // window select
   logic               enable_bit;          // enable as written
   logic [7:0]         config_reg;          // period/window select
   logic [7:0]         early_warn_setup_reg;// warning select
   logic [NUM_IRQ-1:0] irq_enable;          // interrupt mask
   logic [NUM_IRQ-1:0] irq_flags;           // sticky events
   logic               sync_pending_flag;   // enable in flight

   // counter side; the prescaler and the count sit behind the run synchroniser
   // and are held at zero while the counter is stopped, so a restart
   // always begins a full period
   logic               want_run;            // lock or enable
   logic               active;              // synced lock or enable
   logic               active_d;            // active last cycle
   logic [15:0]        tick_cnt;            // tick prescaler
   logic               tick;                // one count step
   logic [CNT_W-1:0]   count;               // watchdog_timer count
   logic [CNT_W-1:0]   limit_per;           // expiry point
   logic [CNT_W-1:0]   limit_win;           // window opens here
   logic [CNT_W-1:0]   limit_warn;          // warning point

   // bus decode; every register is one byte in the low lane, so only
   // byte select zero qualifies a write, and a write with that lane
   // off is acknowledged but changes nothing
   logic               req;                 // live request
   logic               wr;                  // write strobe
   logic               wr_b0;               // low lane written
   logic               ctl_wr;              // control write allowed
   logic               clr_hit;             // valid clear key
   logic               early_clr;           // clear before window
   logic               expire;              // count reached limit
   logic               warn_event;          // warning point hit
   logic               sync_event;          // sync completed
   logic [31:0]        next_dat;            // read mux

   // expiry count for a shift select: a power of two in ticks, with
   // the base shift added so that select zero is still a usable span;
   // shared by the period, the window and the warning point
   function automatic logic [CNT_W-1:0] span(input logic [SEL_W-1:0] s);
      logic [CNT_W-1:0] one;
      one  = '0;
      one[0] = 1'b1;
      span = one << (s + BASE_SHIFT);
   endfunction : span

   // request qualifiers; a request is taken only while ack is low,
   // so a master that holds stb through its ack is not taken twice
   assign req    = cyc_i & stb_i & ~ack_o;
   assign wr     = req & we_i;
   assign wr_b0  = wr & sel_i[0];
   // control writes are refused under the lock; a running counter blocks only
   // the window bit: lock and enable stay reachable while the lock is clear
   assign ctl_wr = wr_b0 & (adr_i == OFS_CONTROL)
                 & ~permanent_run_lock;

   // wishbone ack, one cycle after the request, then dropped; the
   // registered ack gives the decode a whole cycle and lets read data
   // come from a flop in that same cycle; a held request is not
   // answered twice because req is gated by ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   // lock bit: loaded at start-up, then set-only; a zero written to it
   // does nothing, and only rst_i, which stands for power-on reset in
   // this block, brings it back to zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         permanent_run_lock <= nvm_lock_i;
      end else if (ctl_wr && dat_i[BIT_LOCK]) begin
         permanent_run_lock <= 1'b1;
      end
   end

   // enable bit: writable whatever the counter state; the stored value
   // reads back at once, long before the counter follows it, which is
   // why software has the busy flag to poll
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_bit <= nvm_enable_i;
      end else if (ctl_wr) begin
         enable_bit <= dat_i[BIT_ENABLE];
      end
   end

   // window select: blocked while the counter runs, so the open point
   // of the window cannot move under a count in progress; stop the
   // counter first to change it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         window_mode <= nvm_window_i;
      end else if (ctl_wr && !active) begin
         window_mode <= dat_i[BIT_WINDOW];
      end
   end

   // config and warning setup: lock and enable protected; a refused
   // write is still acknowledged and simply leaves the value alone,
   // so software must read back to learn whether it landed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         config_reg           <= RST_CONFIG;
         early_warn_setup_reg <= RST_WARN_SETUP;
      end else if (wr_b0 && !permanent_run_lock && !active) begin
         if (adr_i == OFS_CONFIG) begin
            config_reg <= dat_i[7:0];
         end
         if (adr_i == OFS_WARN_SETUP) begin
            early_warn_setup_reg <= dat_i[7:0];
         end
      end
   end

   // lock forces the run request on; with the lock clear the enable
   // bit alone decides, and once the lock is set a cleared enable no
   // longer stops the counter
   assign want_run = permanent_run_lock | enable_bit;

   // carry the run request into the counting logic; the two stages
   // stand for the crossing into a separate counter clock, and they
   // are why an enable change shows on running_o two cycles late;
   // nothing reads the first stage but the second
   level_sync #(
      .WIDTH (1)
   ) u_run_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (want_run),
      .q_o   (active)
   );

   // completion edge of a synchronised change; the delayed copy makes
   // busy wait one cycle more, so a read of busy low means the counter
   // has settled in the new state; the sync-done flag fires while the
   // change completes and no fresh control write is in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_d <= 1'b0;
      end else begin
         active_d <= active;
      end
   end
   assign sync_event = sync_pending_flag & (active == want_run)
                     & ~ctl_wr;

   // busy: set on an enable write, cleared once applied; a new write
   // wins over a clear in the same cycle so no change goes unreported;
   // a write of the value already in force still raises busy for a
   // cycle or two, which keeps the rule simple for software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_pending_flag <= 1'b0;
      end else if (ctl_wr) begin
         sync_pending_flag <= 1'b1;
      end else if (active == want_run && active == active_d) begin
         sync_pending_flag <= 1'b0;
      end
   end

   // tick prescaler, restarted whenever the counter stops, so every
   // fresh start gives a full first tick rather than a short one left
   // over from the last run
   always_ff @(posedge clk_i) begin
      if (rst_i || !active) begin
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end
   assign tick = (tick_cnt == 16'(TICK_DIV - 1));

   // counter limits from the protected settings; they cannot change
   // while the counter runs, so no compare below ever sees a moving
   // target
   assign limit_per  = span(config_reg[PER_LSB +: SEL_W]);
   assign limit_win  = span(config_reg[WIN_LSB +: SEL_W]);
   assign limit_warn = span(early_warn_setup_reg[SEL_W-1:0]);

   // clear key, early clears only matter in window mode; a wrong key
   // is ignored rather than punished, and a key while stopped does
   // nothing at all
   assign clr_hit   = wr_b0 & (adr_i == OFS_CLEAR)
                    & (dat_i[7:0] == CLEAR_KEY) & active;
   assign early_clr = clr_hit & window_mode
                    & (count < limit_win);
   assign expire    = active & tick & (count >= limit_per - 1'b1);
   assign warn_event = active & tick & (count == limit_warn - 1'b1);

   // watchdog_timer count: restarts on a valid key or on expiry, and is
   // held at zero while the counter is stopped; an early key in window
   // mode restarts it too, alongside the reset pulse
   always_ff @(posedge clk_i) begin
      if (rst_i || !active) begin
         count <= '0;
      end else if (clr_hit || expire) begin
         count <= '0;
      end else if (tick) begin
         count <= count + 1'b1;
      end
   end

   // system reset pulse on expiry or early clear; registered so the
   // pulse is clean and one cycle long; whatever takes the pulse must
   // latch it, since it is not repeated until the next expiry or the
   // next early key
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_reset_o <= 1'b0;
      end else begin
         sys_reset_o <= expire | early_clr;
      end
   end
   assign running_o = active;

   // interrupt enables: set register and clear register; a zero bit
   // written to either leaves that enable as it is, so sources can be
   // handled one at a time without a read-modify-write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_enable <= RST_IE;
      end else if (wr_b0 && adr_i == OFS_IE_CLEAR) begin
         irq_enable <= irq_enable
                     & ~dat_i[NUM_IRQ-1:0];
      end else if (wr_b0 && adr_i == OFS_IE_SET) begin
         irq_enable <= irq_enable | dat_i[NUM_IRQ-1:0];
      end
   end

   // sticky flags: set wins over a write-one clear, so an event that
   // lands in the cycle of the clear is kept and raises the request
   // again right away
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_flags <= '0;
      end else begin
         irq_flags <= (irq_flags
                      & ~((wr_b0 && adr_i == OFS_FLAGS)
                          ? dat_i[NUM_IRQ-1:0] : '0))
                    | {sync_event, warn_event};
      end
   end

   // level request while an enabled flag is set; it falls as soon as
   // the flag is cleared or the enable is taken away, with no pulse
   // stretching of its own
   assign irq_o = |(irq_flags & irq_enable);

   // read data mux, unmapped reads give zero; upper lanes always read
   // zero because every register is one byte wide, and both enable
   // addresses return the same enable bits
   always_comb begin
      next_dat = '0;
      unique case (adr_i)
         OFS_CONTROL: begin
            next_dat[BIT_LOCK]   = permanent_run_lock;
            next_dat[BIT_WINDOW] = window_mode;
            next_dat[BIT_ENABLE] = enable_bit;
         end
         OFS_IE_CLEAR, OFS_IE_SET: begin
            next_dat[NUM_IRQ-1:0] = irq_enable;
         end
         OFS_FLAGS: begin
            next_dat[NUM_IRQ-1:0] = irq_flags;
         end
         OFS_STATUS: begin
            next_dat[BIT_BUSY] = sync_pending_flag;
         end
         OFS_WARN_SETUP: begin
            next_dat[7:0] = early_warn_setup_reg;
         end
         OFS_CONFIG: begin
            next_dat[7:0] = config_reg;
         end
         default: begin
            next_dat = '0;
         end
      endcase
   end

   // read data registered with the ack; it is held until the next
   // read, so it stands in the ack cycle whatever the master does
   // with its strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (req && !we_i) begin
         dat_o <= next_dat;
      end
   end
endmodule : watchdog_ctrl

// file: watchdog_pkg.sv
// constants shared by the watchdog control block
package watchdog_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CONTROL   = 8'h00;
   localparam logic [7:0] OFS_IE_CLEAR  = 8'h04;
   localparam logic [7:0] OFS_IE_SET    = 8'h08;
   localparam logic [7:0] OFS_FLAGS     = 8'h0C;
   localparam logic [7:0] OFS_STATUS    = 8'h10;
   localparam logic [7:0] OFS_WARN_SETUP = 8'h14;
   localparam logic [7:0] OFS_CONFIG    = 8'h18;
   localparam logic [7:0] OFS_CLEAR     = 8'h1C;
   // control register fields
   localparam int BIT_LOCK   = 7;
   localparam int BIT_WINDOW = 2;
   localparam int BIT_ENABLE = 1;
   // interrupt source positions
   localparam int BIT_WARN   = 0;
   localparam int BIT_SYNC   = 1;
   localparam int NUM_IRQ    = 2;
   // status register field
   localparam int BIT_BUSY   = 0;
   // config fields: period select [3:0], window select [7:4]
   localparam int PER_LSB    = 0;
   localparam int WIN_LSB    = 4;
   localparam int SEL_W      = 4;
   // reset values
   localparam logic [7:0] RST_CONFIG   = 8'h0B;
   localparam logic [7:0] RST_WARN_SETUP = 8'h0A;
   localparam logic [NUM_IRQ-1:0] RST_IE = 2'h0;
   // key that restarts the counter
   localparam logic [7:0] CLEAR_KEY = 8'hA5;
   // counter period is two to the power of BASE_SHIFT plus the selected shift, in ticks
   localparam int BASE_SHIFT = 3;
   // tick period of the watchdog count, in ns, and cycles at 4 ns
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS       = 1000;
   localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
   // stages of the enable synchroniser
   localparam int SYNC_STAGES   = 2;
endpackage : watchdog_pkg

// file: level_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,   // block clock
   input  wire logic             rst_i,   // synchronous reset
   input  wire logic [WIDTH-1:0] d_i,     // level to carry over
   output logic      [WIDTH-1:0] q_o      // synchronised level
);
   logic [WIDTH-1:0] stage1;   // first stage, read only by q_o flop

   // plain two-stage chain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage1 <= '0;
         q_o    <= '0;
      end else begin
         stage1 <= d_i;
         q_o    <= stage1;
      end
   end
endmodule : level_sync

// file: watchdog_ctrl_checker.sv
// port assertions for the watchdog control block
`timescale 1ns/100ps
module watchdog_ctrl_checker
   import watchdog_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        nvm_lock_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic        ack_o,
   input wire logic        irq_o,
   input wire logic        sys_reset_o,
   input wire logic        running_o
);
   logic take;    // request taken at this edge
   logic ctl_wr;  // control write taken
   logic locked;  // lock as seen from the bus
   assign take   = cyc_i & stb_i & ~ack_o;
   assign ctl_wr = take & we_i & sel_i[0] & (adr_i == OFS_CONTROL);
   // lock shadow, loaded from the user row in reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         locked <= nvm_lock_i;
      end else if (ctl_wr & dat_i[BIT_LOCK]) begin
         locked <= 1'b1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack; take |=> ack_o; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_ack_one; ack_o |=> !ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("long ack");
   property p_lock_run; ctl_wr & dat_i[BIT_LOCK] |-> ##[1:3] running_o;
   endproperty
   a_lock_run: assert property (p_lock_run)
      else $error("lock not running");
   property p_en_on; ctl_wr & dat_i[BIT_ENABLE] |-> ##[1:3] running_o;
   endproperty
   a_en_on: assert property (p_en_on)
      else $error("enable not applied");
   property p_en_off;
      ctl_wr & ~dat_i[BIT_ENABLE] & ~dat_i[BIT_LOCK] & ~locked
         |-> ##[1:3] !running_o;
   endproperty
   a_en_off: assert property (p_en_off)
      else $error("disable not applied");
   property p_lock_hold; locked & running_o |=> running_o; endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("locked run stopped");
   property p_ie_clr;
      take & we_i & sel_i[0] & (adr_i == OFS_IE_CLEAR)
         & (dat_i[1:0] == 2'b11) |=> !irq_o;
   endproperty
   a_ie_clr: assert property (p_ie_clr)
      else $error("irq after disable");
   property p_pulse; sys_reset_o |=> !sys_reset_o; endproperty
   a_pulse: assert property (p_pulse)
      else $error("reset pulse too long");
endmodule : watchdog_ctrl_checker

// file: watchdog_ctrl_tb_top.sv
// self-checking bench for the watchdog control block
`timescale 1ns/100ps
module watchdog_ctrl_tb_top;
   import watchdog_pkg::*;
   logic        clk_i        = 1'b0;  // 250 MHz clock
   logic        rst_i        = 1'b1;  // reset, high at start
   logic        nvm_lock_i   = 1'b0;  // user row values
   logic        nvm_window_i = 1'b0;
   logic        nvm_enable_i = 1'b0;
   logic        cyc_i        = 1'b0;  // bus request
   logic        stb_i        = 1'b0;
   logic        we_i         = 1'b0;
   logic [7:0]  adr_i        = 8'h00;
   logic [3:0]  sel_i        = 4'hF;
   logic [31:0] dat_i        = 32'h0000_0000;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        irq_o;
   logic        sys_reset_o;
   logic        running_o;
   logic [31:0] q;                    // last read word
   int          bad_count    = 0;
   int          comparisons  = 0;
   int          cycles       = 0;     // timeout count
   int          pulses       = 0;     // reset pulses seen
   int          p0;
   time         t0;                   // instant the warning is seen
   watchdog_ctrl #(.TICK_DIV(4)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .nvm_lock_i(nvm_lock_i),
      .nvm_window_i(nvm_window_i), .nvm_enable_i(nvm_enable_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .irq_o(irq_o), .sys_reset_o(sys_reset_o), .running_o(running_o));
   // free running clock
   always #2 clk_i = ~clk_i;
   // timeout and reset pulse count
   always @(posedge clk_i) begin
      cycles++;
      if (sys_reset_o === 1'b1) pulses++;
      if (cycles == 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   // counts, verdict, stop
   task automatic print_verdict;
      $display("mismatches %0d of %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict
   // one counted comparison
   task automatic chk(input bit ok);
      comparisons++;
      if (!ok) begin
         bad_count++;
         $display("MISMATCH at %0t: wrong value", $time);
      end
   endtask : chk
   // one classic cycle, held until ack is sampled
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [7:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= {24'h00_0000, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      chk(q === {24'h00_0000, e});
   endtask : rd
   // reset for ten cycles with given user row
   task automatic reset(input logic l, w, e);
      nvm_lock_i   <= l;
      nvm_window_i <= w;
      nvm_enable_i <= e;
      rst_i        <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i        <= 1'b0;
      @(posedge clk_i);
   endtask : reset
   // main sequence
   initial begin
      reset(1'b0, 1'b0, 1'b0);
      rd(OFS_CONTROL, 8'h00);
      rd(OFS_IE_CLEAR, 8'h00);
      chk(running_o === 1'b0);
      wr(OFS_CONFIG, 8'h01);
      wr(OFS_WARN_SETUP, 8'h00);
      wr(OFS_CONTROL, 8'h02);
      rd(OFS_STATUS, 8'h01);
      rd(OFS_CONTROL, 8'h02);
      repeat (4) @(posedge clk_i);
      rd(OFS_STATUS, 8'h00);
      chk(running_o === 1'b1);
      rd(OFS_FLAGS, 8'h02);
      wr(OFS_IE_SET, 8'h01);
      rd(OFS_IE_CLEAR, 8'h01);
      while (irq_o !== 1'b1) @(posedge clk_i);
      t0 = $time;
      rd(OFS_FLAGS, 8'h03);
      while (sys_reset_o !== 1'b1) @(posedge clk_i);
      // warning at 8 ticks, expiry at 16, four cycles to a tick
      chk($time - t0 == (16 - 8) * 4 * CLK_PERIOD_NS);
      wr(OFS_CONTROL, 8'h00);
      while (running_o !== 1'b0) @(posedge clk_i);
      wr(OFS_IE_CLEAR, 8'h00);
      rd(OFS_IE_CLEAR, 8'h01);
      chk(irq_o === 1'b1);
      wr(OFS_IE_CLEAR, 8'h03);
      rd(OFS_IE_CLEAR, 8'h00);
      chk(irq_o === 1'b0);
      wr(OFS_IE_SET, 8'h01);
      chk(irq_o === 1'b1);
      wr(OFS_FLAGS, 8'h03);
      chk(irq_o === 1'b0);
      wr(OFS_CONTROL, 8'h04);
      wr(OFS_CONFIG, 8'h11);
      wr(OFS_CONTROL, 8'h06);
      while (running_o !== 1'b1) @(posedge clk_i);
      wr(OFS_CONTROL, 8'h02);
      rd(OFS_CONTROL, 8'h06);
      p0 = pulses;
      wr(OFS_CLEAR, CLEAR_KEY);
      repeat (3) @(posedge clk_i);
      chk(pulses == p0 + 1);
      wr(OFS_CONTROL, 8'h82);
      rd(OFS_CONTROL, 8'h86);
      wr(OFS_CONTROL, 8'h00);
      rd(OFS_CONTROL, 8'h86);
      wr(OFS_CONFIG, 8'h05);
      rd(OFS_CONFIG, 8'h11);
      chk(running_o === 1'b1);
      rd(8'hFC, 8'h00);
      reset(1'b1, 1'b1, 1'b1);
      repeat (2) @(posedge clk_i);
      chk(running_o === 1'b1);
      rd(OFS_CONTROL, 8'h86);
      reset(1'b0, 1'b1, 1'b0);
      rd(OFS_CONTROL, 8'h04);
      print_verdict();
   end
endmodule : watchdog_ctrl_tb_top
bind watchdog_ctrl watchdog_ctrl_checker i_chk (
   .clk_i(clk_i), .rst_i(rst_i), .nvm_lock_i(nvm_lock_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .irq_o(irq_o),
   .sys_reset_o(sys_reset_o), .running_o(running_o));
